/* rtl/epw_write_port.sv */
// external port write-cycle sequencer: chip select, address, strobe, data
`timescale 1ns/100ps
module epw_write_port
    import epw_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int WAIT_W = 3
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    input  wire logic              req_valid_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_data_i,
    input  wire logic [WAIT_W-1:0] wait_count_i,
    input  wire logic              use_wait_i,
    input  wire logic              use_ack_i,
    input  wire logic              write_hold_cycle_enable_i,
    input  wire logic              ack_i,
    output logic                   req_ready_o,
    output logic                   done_o,
    output logic                   peripheral_clock_output_o,
    output logic                   cs_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   wr_n_o,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_n_o
);

    localparam int CNT_W = WAIT_W + 2;  // holds two halves per clock of up to 2^W clocks

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (ADDR_W < 1 || DATA_W < 1 || WAIT_W < 1 || WAIT_W > 8) begin : g_bad_param
        $error("epw_write_port: unsupported width parameter");
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations
    epw_state_t        state_r, state_nxt;   // sequencer
    logic              phase_r;              // divided port clock
    logic [CNT_W-1:0]  wait_left_r;          // halves left in strobe or hold
    logic [CNT_W-1:0]  wait_left_nxt;
    logic [CNT_W-1:0]  strobe_len;           // halves of strobe from waitstates
    logic [WAIT_W-1:0] wait_lat_r;           // latched waitstate count
    logic              ack_lat_r;            // latched ack mode
    logic              wait_lat_en_r;        // latched waitstate mode
    logic              hold_lat_r;           // latched write hold
    logic              ack_seen_r;           // ack seen high at a rise
    logic              ack_pend_r;           // ack seen low, awaiting high
    logic [2:0]        ack_tail_r;           // halves of ack tail left
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_r;
    logic              cs_n_r, wr_n_r, oe_n_r, done_r;
    logic              ext_rise;             // port clock rises this cycle
    logic              accept;               // request taken
    logic              in_strobe;
    logic              wait_done;
    logic              ack_ok;
    logic              strobe_end;
    logic              ack_clean;
    logic              ack_low_now;          // ack sampled low at this port clock rise

    epw_sync_if sif ();

    ////////////////////////////////////////////////////////////////////////
    // acknowledge pin synchroniser
    assign sif.raw   = ack_i;
    assign ack_clean = sif.clean;

    epw_ack_sync u_ack_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .sif    (sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode; system clock runs at twice the port clock so half clocks exist
    assign ext_rise    = ce_i && (phase_r == 1'b0);
    assign req_ready_o = (state_r == EPW_IDLE);
    assign accept      = ce_i && req_valid_i && req_ready_o;
    assign in_strobe   = (state_r == EPW_STROBE);
    // base of one clock, one more per programmed waitstate
    assign strobe_len  = CNT_W'(HALF_PER_CLK) *
                         (CNT_W'(1) + (wait_lat_en_r ? CNT_W'(wait_lat_r) : CNT_W'(0)));
    assign wait_done   = (wait_left_r == CNT_W'(0));
    // without ack mode the ack pin is ignored entirely
    assign ack_low_now = ext_rise && !ack_clean;
    // a low sample at this rise holds the access even if ack was seen high before
    assign ack_ok      = !ack_lat_r ||
                         (ack_seen_r && (ack_tail_r == 3'h0) && !ack_low_now);
    assign strobe_end  = in_strobe && wait_done && ack_ok;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_nxt     = state_r;
        wait_left_nxt = wait_left_r;
        if (wait_left_r != CNT_W'(0)) begin
            wait_left_nxt = wait_left_r - CNT_W'(1);
        end
        case (state_r)
            EPW_IDLE: begin
                if (accept) begin
                    state_nxt = EPW_SETUP;  // select and address lead the strobe
                end
            end
            EPW_SETUP: begin
                state_nxt     = EPW_STROBE;
                wait_left_nxt = strobe_len - CNT_W'(1);
            end
            EPW_STROBE: begin
                if (strobe_end) begin
                    state_nxt = EPW_REL;
                end
            end
            EPW_REL: begin
                // one half after the strobe, select lets go; data too unless write hold is on
                if (hold_lat_r) begin
                    state_nxt     = EPW_HOLD;
                    wait_left_nxt = CNT_W'(HOLD_HALVES - 1);
                end else begin
                    state_nxt = EPW_GAP;
                end
            end
            EPW_HOLD: begin
                if (wait_done) begin
                    state_nxt = EPW_GAP;
                end
            end
            EPW_GAP: begin
                state_nxt = EPW_IDLE;       // keeps a port clock between strobes
            end
            default: begin
                state_nxt = EPW_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and port clock divider
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r     <= EPW_IDLE;
            wait_left_r <= '0;
            phase_r     <= PHASE_RST;
        end else if (ce_i) begin
            state_r     <= state_nxt;
            wait_left_r <= wait_left_nxt;
            phase_r     <= !phase_r;
        end
    end

    assign peripheral_clock_output_o = phase_r;

    ////////////////////////////////////////////////////////////////////////
    // request capture; settings are frozen for the whole access
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_r        <= '0;
            data_r        <= '0;
            wait_lat_r    <= '0;
            wait_lat_en_r <= 1'b0;
            ack_lat_r     <= 1'b0;
            hold_lat_r    <= 1'b0;
        end else if (accept) begin
            addr_r        <= req_addr_i;
            data_r        <= req_data_i;
            wait_lat_r    <= wait_count_i;
            wait_lat_en_r <= use_wait_i;
            ack_lat_r     <= use_ack_i;
            hold_lat_r    <= write_hold_cycle_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acknowledge tracking, sampled only on port clock rises
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_seen_r <= 1'b0;
            ack_pend_r <= 1'b0;
            ack_tail_r <= 3'h0;
        end else if (ce_i) begin
            if (!in_strobe) begin
                ack_seen_r <= 1'b0;
                ack_pend_r <= 1'b0;
                ack_tail_r <= 3'h0;
            end else begin
                if (ack_tail_r != 3'h0) begin
                    ack_tail_r <= ack_tail_r - 3'h1;
                end
                if (ext_rise && ack_lat_r) begin
                    if (!ack_clean) begin
                        ack_seen_r <= 1'b0;
                        ack_pend_r <= 1'b1;
                    end else if (ack_pend_r || !ack_seen_r) begin
                        ack_seen_r <= 1'b1;
                        ack_pend_r <= 1'b0;
                        // a stall already happened: finish after the tail
                        ack_tail_r <= ack_pend_r ? ACK_TAIL_HALVES : 3'h0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pin levels, decoded from the next state to avoid glitches; done from the current state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cs_n_r <= PIN_INACTIVE;
            wr_n_r <= PIN_INACTIVE;
            oe_n_r <= PIN_INACTIVE;
            done_r <= 1'b0;
        end else if (ce_i) begin
            cs_n_r <= !(state_nxt inside {EPW_SETUP, EPW_STROBE, EPW_REL});
            wr_n_r <= (state_nxt != EPW_STROBE);
            oe_n_r <= !(state_nxt inside {EPW_STROBE, EPW_REL, EPW_HOLD});
            done_r <= (state_r == EPW_GAP);
        end
    end

    assign cs_n_o      = cs_n_r;
    assign wr_n_o      = wr_n_r;
    assign data_oe_n_o = oe_n_r;
    assign addr_o      = addr_r;
    assign data_o      = data_r;
    assign done_o      = done_r && ce_i;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    logic [CNT_W:0] low_cnt_r;  // helper: cycles of strobe low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            low_cnt_r <= '0;
        end else if (ce_i) begin
            low_cnt_r <= wr_n_r ? '0 : low_cnt_r + (CNT_W+1)'(1);
        end
    end

    sequence s_release;
        !data_oe_n_o ##1 data_oe_n_o;
    endsequence
    sequence s_hold_release;
        !data_oe_n_o [*3] ##1 data_oe_n_o;
    endsequence
    sequence s_tail;
        !wr_n_o [*5] ##1 wr_n_o;
    endsequence

    chk_cs_leads_wr:    assert property ($fell(wr_n_o) |-> !cs_n_o && $past(!cs_n_o))
        else $error("strobe fell without select set up");
    // a strobe cut by reset also rises; the past-reset term keeps that out
    chk_cs_trails_wr:   assert property ($rose(wr_n_o) && !$past(srst_i)
                                         |-> !cs_n_o ##1 cs_n_o)
        else $error("select not held past strobe");
    chk_strobe_width:   assert property ($rose(wr_n_o) && !$past(srst_i) && !ack_lat_r
                                         |-> low_cnt_r == {1'b0, strobe_len})
        else $error("strobe width differs from waitstate count");
    chk_data_on_strobe: assert property (!wr_n_o |-> !data_oe_n_o)
        else $error("data not driven during strobe");
    chk_data_release:   assert property ($rose(wr_n_o) && !$past(srst_i) && !hold_lat_r
                                         |-> s_release)
        else $error("data release not half a clock after strobe");
    chk_write_hold:     assert property ($rose(wr_n_o) && !$past(srst_i) && hold_lat_r
                                         |-> s_hold_release)
        else $error("write hold did not add one clock");
    chk_ack_stall:      assert property (in_strobe && ext_rise && ack_lat_r && !ack_clean
                                         |-> ##1 !wr_n_o [*5])
        else $error("access completed while ack low");
    chk_ack_tail:       assert property (in_strobe && ext_rise && ack_lat_r && ack_clean &&
                                         ack_pend_r && wait_done |-> ##1 s_tail)
        else $error("ack tail not two port clocks");
    // only edges that really run the divider are followed by a toggle
    chk_clock_out:      assert property (!srst_i && ce_i |=> peripheral_clock_output_o
                                         != $past(peripheral_clock_output_o))
        else $error("peripheral clock output stalled");

endmodule : epw_write_port

/* common/epw_pkg.sv */
// shared constants and state encoding of the external port write sequencer
package epw_pkg;

    // system clock rate; one system cycle is half of one external port clock
    localparam int          SYS_CLK_MHZ      = 125;
    localparam int          HALF_PER_CLK     = 2;

    // acknowledge tail: external port clocks from ack seen high to completion
    localparam int          ACK_TAIL_CLKS    = 2;
    localparam logic [2:0]  ACK_TAIL_HALVES  = 3'(ACK_TAIL_CLKS * HALF_PER_CLK);

    // extra data hold with write hold enabled: one external port clock
    localparam int          HOLD_CLKS        = 1;
    localparam int          HOLD_HALVES      = HOLD_CLKS * HALF_PER_CLK;

    // reset levels of the pins
    localparam logic        PIN_INACTIVE     = 1'b1;
    localparam logic        ACK_IDLE_LEVEL   = 1'b1;
    localparam logic        PHASE_RST        = 1'b0;

    // sequencer states
    typedef enum logic [2:0] {
        EPW_IDLE   = 3'b000,
        EPW_SETUP  = 3'b001,
        EPW_STROBE = 3'b010,
        EPW_REL    = 3'b011,
        EPW_HOLD   = 3'b100,
        EPW_GAP    = 3'b101
    } epw_state_t;

endpackage : epw_pkg

/* common/epw_sync_if.sv */
// carrier between the acknowledge synchroniser and the sequencer
`timescale 1ns/100ps
interface epw_sync_if;
    logic raw;    // acknowledge pin level, asynchronous
    logic clean;  // settled, synchronised level

    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : epw_sync_if

/* rtl/epw_ack_sync.sv */
// three-stage synchroniser with agreement filter for the acknowledge pin
`timescale 1ns/100ps
module epw_ack_sync
    import epw_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    epw_sync_if.sync  sif
);

    logic [2:0] stage_r;  // stage 0 is metastable, only stage 1 reads it
    logic       clean_r;  // filtered level

    ////////////////////////////////////////////////////////////////////////
    // shift chain; a change counts only once stages 1 and 2 agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stage_r <= {3{ACK_IDLE_LEVEL}};
            clean_r <= ACK_IDLE_LEVEL;
        end else if (ce_i) begin
            stage_r <= {stage_r[1:0], sif.raw};
            if (stage_r[1] == stage_r[2]) begin
                clean_r <= stage_r[2];
            end
        end
    end

    assign sif.clean = clean_r;

endmodule : epw_ack_sync

/* dv/epw_mem_model.sv */
// external memory model: captures writes, drives acknowledge, watches strobe timing
`timescale 1ns/100ps
module epw_mem_model #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    input  wire logic              pclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              wr_n_i,
    input  wire logic              data_oe_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              use_ack_i,
    input  wire logic [3:0]        stretch_i,
    output logic                   ack_o,
    output int                     wr_count_o,
    output logic [ADDR_W-1:0]      last_addr_o,
    output logic [DATA_W-1:0]      last_data_o,
    output int                     strobe_len_o,
    output int                     tail_len_o,
    output int                     viol_o
);
    logic              wr_n_q = 1'b1, cs_n_q = 1'b1, pclk_q = 1'b0, ce_q = 1'b0, rst_q = 1'b1;
    logic              acked = 1'b0;     // ack was low during this strobe
    logic [ADDR_W-1:0] addr_q;
    int                low_cnt = 0, hi_cnt = 99, rises_left = 0, since_ack = 0;

    initial begin
        ack_o = 1'b1; wr_count_o = 0; strobe_len_o = 0; tail_len_o = 0; viol_o = 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks read pre-edge values; ack changes only by nba so the port sees it cleanly
    always @(posedge clk_i) begin
        if (ce_q && !rst_q && pclk_i == pclk_q) viol_o++;
        if (!srst_i && !wr_n_i) begin
            if (cs_n_i || data_oe_n_i) viol_o++;
            if (wr_n_q && (cs_n_q || hi_cnt < 2)) viol_o++;
            if (!wr_n_q && addr_i != addr_q) viol_o++;
            if (!ack_o) acked = 1'b1;
            low_cnt = wr_n_q ? 1 : low_cnt + 1;
        end
        if (!srst_i && wr_n_i && !wr_n_q) begin
            wr_count_o++;
            last_addr_o = addr_i;
            last_data_o = data_i;
            strobe_len_o = low_cnt;
            tail_len_o = data_oe_n_i ? 0 : 1;
            if (cs_n_i) viol_o++;
            if (use_ack_i && !ack_o) viol_o++;
            if (use_ack_i && acked && (since_ack < 4 || since_ack > 16)) viol_o++;
            acked = 1'b0;
        end else if (wr_n_i && !data_oe_n_i) tail_len_o++;
        hi_cnt = wr_n_i ? hi_cnt + 1 : 0;
        since_ack++;
        // slow device: ack low while deselected, high after a set number of clock rises
        if (stretch_i == 4'h0) ack_o <= 1'b1;
        else if (cs_n_i) begin
            ack_o <= 1'b0;
            rises_left = stretch_i;
        end else if (!wr_n_i && pclk_i == 1'b0) begin
            if (rises_left > 0) rises_left--;
            else if (!ack_o) begin
                ack_o <= 1'b1;
                since_ack = 0;
            end
        end
        wr_n_q = wr_n_i; cs_n_q = cs_n_i; pclk_q = pclk_i; ce_q = ce_i; rst_q = srst_i;
        addr_q = addr_i;
    end
endmodule : epw_mem_model

/* dv/tb_top.sv */
// self-checking bench of the external port write sequencer
`timescale 1ns/100ps
module tb_top;
    import epw_pkg::*;
    typedef struct { logic [2:0] w; logic uw, hold, ua; logic [3:0] st;
                     logic [21:0] a; logic [15:0] d; } epw_row_t;
    logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, req_valid_i = 1'b0;
    logic [21:0] req_addr_i = 22'h0, addr_o, last_addr;
    logic [15:0] req_data_i = 16'h0, data_o, last_data;
    logic [2:0]  wait_count_i = 3'h0;
    logic        use_wait_i = 1'b0, use_ack_i = 1'b0, write_hold_cycle_enable_i = 1'b0;
    logic        ack_i, req_ready_o, done_o, pclk, cs_n_o, wr_n_o, data_oe_n_o;
    logic [3:0]  stretch = 4'h0;
    int          failures = 0, tests_run = 0, wr_count, strobe_len, tail_len, viol, lat, n0;
    epw_row_t    rows [8] = '{
        '{3'h0, 1'b1, 1'b0, 1'b0, 4'h0, 22'h000000, 16'h0001},
        '{3'h3, 1'b1, 1'b1, 1'b0, 4'h0, 22'h3fffff, 16'hffff},
        '{3'h7, 1'b0, 1'b0, 1'b0, 4'h3, 22'h155555, 16'ha5a5},
        '{3'h7, 1'b1, 1'b1, 1'b0, 4'h0, 22'h2aaaaa, 16'h5a5a},
        '{3'h0, 1'b0, 1'b0, 1'b1, 4'h3, 22'h000100, 16'h1234},
        '{3'h3, 1'b1, 1'b0, 1'b1, 4'h1, 22'h000200, 16'h4321},
        '{3'h6, 1'b1, 1'b1, 1'b1, 4'h2, 22'h000300, 16'h0f0f},
        '{3'h5, 1'b1, 1'b0, 1'b1, 4'h0, 22'h000400, 16'hf0f0}};

    always #4 clk_i = ~clk_i;

    epw_write_port DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
        .req_addr_i(req_addr_i), .req_data_i(req_data_i), .wait_count_i(wait_count_i),
        .use_wait_i(use_wait_i), .use_ack_i(use_ack_i),
        .write_hold_cycle_enable_i(write_hold_cycle_enable_i), .ack_i(ack_i),
        .req_ready_o(req_ready_o), .done_o(done_o), .peripheral_clock_output_o(pclk),
        .cs_n_o(cs_n_o), .addr_o(addr_o), .wr_n_o(wr_n_o), .data_o(data_o),
        .data_oe_n_o(data_oe_n_o));

    epw_mem_model MEM (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .pclk_i(pclk),
        .cs_n_i(cs_n_o), .wr_n_i(wr_n_o), .data_oe_n_i(data_oe_n_o), .addr_i(addr_o),
        .data_i(data_o), .use_ack_i(use_ack_i), .stretch_i(stretch), .ack_o(ack_i),
        .wr_count_o(wr_count), .last_addr_o(last_addr), .last_data_o(last_data),
        .strobe_len_o(strobe_len), .tail_len_o(tail_len), .viol_o(viol));

    ////////////////////////////////////////////////////////////////////////////
    // compare and count; reports mismatches only
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // polls after each edge, so done is seen in the cycle it stands
    task automatic wait_done(output int n);
        n = 0;
        repeat (300) begin
            @(posedge clk_i);
            #1 n++;
            if (done_o === 1'b1) break;
        end
        chk("done seen", 1'b1, done_o);
    endtask : wait_done

    // raise a request, drop it at the edge that takes it, then wait for done
    task automatic send(input epw_row_t r, output int n);
        @(posedge clk_i);
        {wait_count_i, use_wait_i, write_hold_cycle_enable_i, use_ack_i} <= {r.w, r.uw, r.hold, r.ua};
        stretch <= r.st;
        // the partner settles its ack level first: the pin passes a three-flop synchroniser
        repeat (6) @(posedge clk_i);
        {req_addr_i, req_data_i, req_valid_i} <= {r.a, r.d, 1'b1};
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        wait_done(n);
    endtask : send

    task automatic chk_idle();
        chk("idle pins", 4'hf, {cs_n_o, wr_n_o, data_oe_n_o, req_ready_o});
        chk("idle rest", 3'h0, {done_o, pclk, |addr_o, |data_o});
    endtask : chk_idle

    initial begin
        #200000 failures++;
        tally_and_finish();
    end

    initial begin
        int s;
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        #1 chk_idle();
        foreach (rows[i]) begin
            s = 2 * (1 + (rows[i].uw ? rows[i].w : 0));
            send(rows[i], lat);
            chk("last data", rows[i].d, last_data);
            chk("last addr", rows[i].a, last_addr);
            chk("tail", rows[i].hold ? 3 : 1, tail_len);
            if (rows[i].ua === 1'b0) begin
                chk("strobe", s, strobe_len);
                chk("latency", s + (rows[i].hold ? 5 : 3), lat);
            end else begin
                chk("strobe min", 1, strobe_len >= s && strobe_len >= 2 * rows[i].st);
                chk("strobe max", 1, strobe_len <= s + 2 * rows[i].st + 16);
            end
        end
        // level request held through two accesses: the second is refused until ready
        n0 = wr_count;
        send(rows[0], lat);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_data_i <= 16'h1111;
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_data_i <= 16'h2222;
        wait_done(lat);
        chk("refused", 16'h1111, last_data);
        chk("ready at done", 1'b1, req_ready_o);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        wait_done(lat);
        chk("second", 16'h2222, last_data);
        chk("b2b count", n0 + 3, wr_count);
        // clock enable low for six cycles in mid strobe freezes everything
        fork
            send(rows[3], lat);
            begin
                @(negedge wr_n_o);
                @(posedge clk_i);
                ce_i <= 1'b0;
                repeat (6) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        chk("frozen strobe", 16 + 6, strobe_len);
        chk("frozen latency", 16 + 5 + 6, lat);
        // reset in mid access returns all pins to idle
        @(posedge clk_i);
        {wait_count_i, use_wait_i, use_ack_i, req_valid_i} <= {3'h7, 1'b1, 1'b0, 1'b1};
        repeat (5) @(posedge clk_i);
        {req_valid_i, srst_i} <= 2'b01;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        #1 chk_idle();
        chk("model", 0, viol);
        tally_and_finish();
    end
endmodule : tb_top
